// File: rtl/dtp_pkg.sv
// constants and types shared by the debug trace output path
package dtp_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DTP_BYTE_W = 8;
	localparam int DTP_TS_W = 21;
	localparam int DTP_FIFO_DEPTH = 8;
	// ----------------------------------------
	// packet headers (first byte of each packet), plus the source id byte and the zero padding byte
	// ----------------------------------------
	localparam logic [7:0] DTP_HDR_SW = 8'h01;
	localparam logic [7:0] DTP_HDR_HW_MATCH = 8'h05;
	localparam logic [7:0] DTP_HDR_EXC = 8'h0e;
	localparam logic [7:0] DTP_HDR_PC = 8'h17;
	localparam logic [7:0] DTP_HDR_TS = 8'hc0;
	localparam logic [7:0] DTP_SRC_ID = 8'h03;
	localparam logic [7:0] DTP_ZERO_BYTE = 8'h00;
	// ----------------------------------------
	// exception trace kinds
	// ----------------------------------------
	localparam logic [1:0] DTP_EXC_ENTRY = 2'h1;
	localparam logic [1:0] DTP_EXC_EXIT = 2'h2;
	localparam logic [1:0] DTP_EXC_RETURN = 2'h3;
	// ----------------------------------------
	// comparator function codes
	// ----------------------------------------
	localparam logic [1:0] DTP_FN_OFF = 2'h0;
	localparam logic [1:0] DTP_FN_TRACE = 2'h1;
	localparam logic [1:0] DTP_FN_HALT = 2'h2;
	localparam logic [1:0] DTP_FN_PC_SAMPLE = 2'h3;
	// ----------------------------------------
	// output mode
	// ----------------------------------------
	localparam logic [1:0] DTP_MODE_OFF = 2'h0;
	localparam logic [1:0] DTP_MODE_SINGLE = 2'h1;
	localparam logic [1:0] DTP_MODE_PARALLEL = 2'h2;
	// ----------------------------------------
	// arbiter state
	// ----------------------------------------
	typedef enum logic [1:0] {
		DTP_ARB_IDLE = 2'b00,
		DTP_ARB_SEND = 2'b01
	} dtp_arb_t;
endpackage

// File: rtl/dtp_sync_fifo_cdc.sv
// asynchronous FIFO with gray-coded pointers between source and trace clocks
`timescale 1ns/100ps
module dtp_async_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH_LOG2 = 3
) (
	// write side
	input wire logic wr_clock,
	input wire logic wr_reset,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic rd_clock,
	input wire logic rd_reset,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data
);
	localparam int PW = DEPTH_LOG2 + 1;
	logic [WIDTH-1:0] store [0:(1<<DEPTH_LOG2)-1];
	logic [PW-1:0] wr_bin, wr_gray, rd_bin, rd_gray;
	logic [PW-1:0] rg_s1, rg_s2, wg_s1, wg_s2;
	logic [PW-1:0] next_wr_bin, next_rd_bin;
	logic do_wr, do_rd;

	// full when the far pointer differs only in the two top bits
	assign wr_ready = (wr_gray != {~rg_s2[PW-1:PW-2], rg_s2[PW-3:0]});
	assign rd_valid = (rd_gray != wg_s2);
	assign rd_data = store[rd_bin[DEPTH_LOG2-1:0]];
	assign do_wr = wr_valid & wr_ready;
	assign do_rd = rd_valid & rd_ready;

	// next pointers
	always_comb begin
		next_wr_bin = wr_bin + PW'(do_wr);
		next_rd_bin = rd_bin + PW'(do_rd);
	end

	// write domain pointer, read pointer synchronised in
	always_ff @(posedge wr_clock or posedge wr_reset) begin
		if (wr_reset) begin
			wr_bin <= '0;
			wr_gray <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else begin
			wr_bin <= next_wr_bin;
			wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
			rg_s1 <= rd_gray;
			rg_s2 <= rg_s1;
		end
	end

	// storage has no reset; only written slots are ever read
	always_ff @(posedge wr_clock) begin
		if (do_wr) begin
			store[wr_bin[DEPTH_LOG2-1:0]] <= wr_data;
		end
	end

	// read domain pointer, write pointer synchronised in
	always_ff @(posedge rd_clock or posedge rd_reset) begin
		if (rd_reset) begin
			rd_bin <= '0;
			rd_gray <= '0;
			wg_s1 <= '0;
			wg_s2 <= '0;
		end else begin
			rd_bin <= next_rd_bin;
			rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
			wg_s1 <= wr_gray;
			wg_s2 <= wg_s1;
		end
	end
endmodule

// File: rtl/dtp_trace_out.sv
// trace-clock side: optional source-id formatter and serializer onto pins
`timescale 1ns/100ps
module dtp_trace_out
	import dtp_pkg::*;
(
	// clock and reset
	input wire logic trace_clock,
	input wire logic trace_reset,
	// byte stream from the FIFO
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	// configuration, already synchronised
	input wire logic [1:0] mode,
	input wire logic formatter_on,
	// pins
	output logic single_wire_trace_out_a,
	output logic single_wire_trace_out_b,
	output logic trace_port_clock,
	output logic trace_lane_zero,
	output logic trace_lane_one,
	output logic trace_lane_two,
	output logic trace_lane_three
);
	// a byte holds for eight bit times or two nibble times
	localparam logic [3:0] LOAD_SINGLE = 4'h8;
	localparam logic [3:0] LOAD_PAR = 4'h2;
	logic [7:0] shreg, next_shreg;
	logic [3:0] left, next_left;
	logic id_due, next_id_due;
	logic tclk, next_tclk;
	logic [5:0] pins, next_pins;
	logic loading;

	// the shifter empties bit per clock (single) or nibble per clock (parallel)
	always_comb begin
		next_shreg = shreg;
		next_left = left;
		next_id_due = id_due;
		next_tclk = (mode == DTP_MODE_PARALLEL) ? ~tclk : 1'b0;
		in_ready = 1'b0;
		// reload in the cycle the last unit is registered onto the pins, so queued bytes leave without a gap
		loading = (left <= 4'h1) && (mode != DTP_MODE_OFF);
		// the id goes out only ahead of real data, never on an idle line
		if (loading && in_valid && formatter_on && id_due) begin
			next_shreg = DTP_SRC_ID;
			next_id_due = 1'b0;
			next_left = (mode == DTP_MODE_PARALLEL) ? LOAD_PAR : LOAD_SINGLE;
		end else if (loading && in_valid) begin
			in_ready = 1'b1;
			next_shreg = in_data;
			next_id_due = 1'b1;
			next_left = (mode == DTP_MODE_PARALLEL) ? LOAD_PAR : LOAD_SINGLE;
		end else if (left != 4'h0) begin
			next_shreg = (mode == DTP_MODE_PARALLEL) ? {4'h0, shreg[7:4]} : {1'b0, shreg[7:1]};
			next_left = left - 4'h1;
		end
		// idle line: single wire high in single mode, lanes low
		next_pins = 6'h00;
		if (mode == DTP_MODE_SINGLE) begin
			next_pins[0] = (left != 4'h0) ? shreg[0] : 1'b1;
		end else if (mode == DTP_MODE_PARALLEL) begin
			next_pins[5:2] = (left != 4'h0) ? shreg[3:0] : 4'h0;
		end
	end

	always_ff @(posedge trace_clock or posedge trace_reset) begin
		if (trace_reset) begin
			shreg <= '0;
			left <= '0;
			id_due <= 1'b1;
			tclk <= 1'b0;
			pins <= '0;
		end else begin
			shreg <= next_shreg;
			left <= next_left;
			id_due <= next_id_due;
			tclk <= next_tclk;
			pins <= next_pins;
		end
	end

	// lane zero shares a pin with the single wire, so only one carries data
	assign single_wire_trace_out_a = pins[0];
	assign single_wire_trace_out_b = pins[0];
	assign trace_port_clock = tclk;
	assign trace_lane_zero = pins[2];
	assign trace_lane_one = pins[3];
	assign trace_lane_two = pins[4];
	assign trace_lane_three = pins[5];
endmodule

// File: rtl/dtp_trace_path.sv
// top: packet source, profiling unit, FIFO and trace output stage
`timescale 1ns/100ps
module dtp_trace_path
	import dtp_pkg::*;
#(
	parameter int PC_W = 32,
	parameter int FIFO_LOG2 = 3
) (
	// core clock domain
	input wire logic clock,
	input wire logic reset,
	// software stimulus write
	input wire logic stim_write,
	input wire logic [7:0] stim_data,
	input wire logic trace_enable,
	input wire logic timestamp_enable,
	// profiling unit events
	input wire logic exc_trace_enable,
	input wire logic exc_event,
	input wire logic [1:0] exc_kind,
	input wire logic [7:0] exc_number,
	input wire logic [PC_W-1:0] core_pc,
	input wire logic [PC_W-1:0] data_addr,
	input wire logic data_access,
	input wire logic [PC_W-1:0] comp_value,
	input wire logic [PC_W-1:0] comp_mask,
	input wire logic [1:0] comp_function,
	input wire logic [31:0] cycle_compare,
	input wire logic pc_sample_enable,
	// output configuration
	input wire logic [1:0] out_mode,
	input wire logic formatter_enable,
	// core status
	output logic stim_busy,
	output logic halt_request,
	// trace clock domain and pins
	input wire logic trace_clock,
	input wire logic trace_reset,
	output logic single_wire_trace_out_a,
	output logic single_wire_trace_out_b,
	output logic trace_port_clock,
	output logic trace_lane_zero,
	output logic trace_lane_one,
	output logic trace_lane_two,
	output logic trace_lane_three
);
	// ----------------------------------------
	// profiling unit: comparator and cycle counter
	// ----------------------------------------
	logic [31:0] cycles, next_cycles;
	logic match, cyc_hit;
	logic halt, next_halt;
	logic hw_pend, next_hw_pend;
	logic [7:0] hw_hdr, next_hw_hdr;
	logic [7:0] hw_pay, next_hw_pay;
	logic sw_pend, next_sw_pend;
	logic [7:0] sw_pay, next_sw_pay;
	logic [DTP_TS_W-1:0] ts, next_ts;
	logic ts_pend, next_ts_pend;
	logic hw_take, sw_take, ts_take;

	// masked match against data address
	assign match = data_access && (((data_addr ^ comp_value) & ~comp_mask) == '0);
	assign cyc_hit = pc_sample_enable && (comp_function == DTP_FN_PC_SAMPLE) && (cycles == cycle_compare);

	always_comb begin
		next_cycles = cycles + 32'h1;
		next_halt = halt;
		next_hw_pend = hw_pend;
		next_hw_hdr = hw_hdr;
		next_hw_pay = hw_pay;
		// a taken packet frees the slot; a new event in the same cycle is dropped, since hw_pend still blocks it
		if (hw_take) begin
			next_hw_pend = 1'b0;
		end
		if (match && comp_function == DTP_FN_HALT) begin
			next_halt = 1'b1;
		end else if (exc_trace_enable && exc_event && exc_kind != 2'h0 && !hw_pend) begin
			next_hw_pend = 1'b1;
			next_hw_hdr = DTP_HDR_EXC | {4'h0, exc_kind, 2'h0};
			next_hw_pay = exc_number;
		end else if (match && comp_function == DTP_FN_TRACE && !hw_pend) begin
			next_hw_pend = 1'b1;
			next_hw_hdr = DTP_HDR_HW_MATCH;
			next_hw_pay = data_addr[7:0];
		end else if (cyc_hit && !hw_pend) begin
			next_hw_pend = 1'b1;
			next_hw_hdr = DTP_HDR_PC;
			next_hw_pay = core_pc[7:0];
		end
	end

	// ----------------------------------------
	// packet source: stimulus port and timestamp
	// ----------------------------------------
	always_comb begin
		next_sw_pend = sw_pend & ~sw_take;
		next_sw_pay = sw_pay;
		if (stim_write && trace_enable && !sw_pend) begin
			next_sw_pend = 1'b1;
			next_sw_pay = stim_data;
		end
		// timestamp runs between packets and is emitted after one
		next_ts = ts_take ? '0 : ts + DTP_TS_W'(1);
		next_ts_pend = (ts_pend & ~ts_take) | (timestamp_enable && (sw_take || hw_take));
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cycles <= '0;
			halt <= 1'b0;
			hw_pend <= 1'b0;
			hw_hdr <= '0;
			hw_pay <= '0;
			sw_pend <= 1'b0;
			sw_pay <= '0;
			ts <= '0;
			ts_pend <= 1'b0;
		end else begin
			cycles <= next_cycles;
			halt <= next_halt;
			hw_pend <= next_hw_pend;
			hw_hdr <= next_hw_hdr;
			hw_pay <= next_hw_pay;
			sw_pend <= next_sw_pend;
			sw_pay <= next_sw_pay;
			ts <= next_ts;
			ts_pend <= next_ts_pend;
		end
	end

	// ----------------------------------------
	// arbiter and packet byte sequencer
	// ----------------------------------------
	dtp_arb_t state, next_state;
	logic [1:0] idx, next_idx, len, next_len;
	logic [7:0] pkt [0:3];
	logic [7:0] next_pkt [0:3];
	logic f_valid, f_ready;
	logic [7:0] f_data;
	logic pick;

	always_comb begin
		next_state = state;
		next_idx = idx;
		next_len = len;
		next_pkt = pkt;
		sw_take = 1'b0;
		hw_take = 1'b0;
		ts_take = 1'b0;
		f_valid = (state == DTP_ARB_SEND);
		f_data = pkt[idx];
		pick = 1'b0;
		unique case (state)
			DTP_ARB_IDLE: begin
				pick = 1'b1;
			end
			DTP_ARB_SEND: begin
				// the byte stays offered until the FIFO has room
				if (f_ready) begin
					if (idx == len) begin
						next_state = DTP_ARB_IDLE;
						pick = 1'b1;
					end else begin
						next_idx = idx + 2'h1;
					end
				end
			end
		endcase
		// a waiting packet follows the last byte directly, keeping the stream dense
		if (pick) begin
				if (sw_pend) begin
					sw_take = 1'b1;
					next_pkt = '{DTP_HDR_SW, sw_pay, DTP_ZERO_BYTE, DTP_ZERO_BYTE};
					next_len = 2'h1;
				end else if (hw_pend) begin
					hw_take = 1'b1;
					next_pkt = '{hw_hdr, hw_pay, DTP_ZERO_BYTE, DTP_ZERO_BYTE};
					next_len = 2'h1;
				end else if (ts_pend) begin
					ts_take = 1'b1;
					next_pkt = '{DTP_HDR_TS, {1'b1, ts[6:0]}, {1'b1, ts[13:7]}, {1'b0, ts[20:14]}};
					next_len = 2'h3;
				end
				if (sw_pend || hw_pend || ts_pend) begin
					next_state = DTP_ARB_SEND;
					next_idx = 2'h0;
				end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= DTP_ARB_IDLE;
			idx <= '0;
			len <= '0;
			pkt <= '{default: '0};
			stim_busy <= 1'b0;
			halt_request <= 1'b0;
		end else begin
			state <= next_state;
			idx <= next_idx;
			len <= next_len;
			pkt <= next_pkt;
			stim_busy <= next_sw_pend;
			halt_request <= next_halt;
		end
	end

	// ----------------------------------------
	// crossing into the trace clock
	// ----------------------------------------
	logic t_valid, t_ready;
	logic [7:0] t_data;
	logic [2:0] cfg_s1, cfg_s2;

	dtp_async_fifo #(
		.WIDTH(DTP_BYTE_W),
		.DEPTH_LOG2(FIFO_LOG2)
	) u_fifo (
		.wr_clock(clock),
		.wr_reset(reset),
		.wr_valid(f_valid),
		.wr_ready(f_ready),
		.wr_data(f_data),
		.rd_clock(trace_clock),
		.rd_reset(trace_reset),
		.rd_valid(t_valid),
		.rd_ready(t_ready),
		.rd_data(t_data)
	);

	// static configuration levels, two flops into the trace domain
	always_ff @(posedge trace_clock or posedge trace_reset) begin
		if (trace_reset) begin
			cfg_s1 <= '0;
			cfg_s2 <= '0;
		end else begin
			cfg_s1 <= {formatter_enable, out_mode};
			cfg_s2 <= cfg_s1;
		end
	end

	dtp_trace_out u_out (
		.trace_clock(trace_clock),
		.trace_reset(trace_reset),
		.in_valid(t_valid),
		.in_ready(t_ready),
		.in_data(t_data),
		.mode(cfg_s2[1:0]),
		.formatter_on(cfg_s2[2]),
		.single_wire_trace_out_a(single_wire_trace_out_a),
		.single_wire_trace_out_b(single_wire_trace_out_b),
		.trace_port_clock(trace_port_clock),
		.trace_lane_zero(trace_lane_zero),
		.trace_lane_one(trace_lane_one),
		.trace_lane_two(trace_lane_two),
		.trace_lane_three(trace_lane_three)
	);
endmodule

// File: tb/dtp_trace_path_properties.sv
// concurrent checks on the status outputs and pins of the trace path
`timescale 1ns/100ps
module dtp_trace_checker
	import dtp_pkg::*;
(
	// core domain
	input wire logic clock,
	input wire logic reset,
	input wire logic stim_write,
	input wire logic trace_enable,
	input wire logic [1:0] comp_function,
	input wire logic stim_busy,
	input wire logic halt_request,
	// trace domain
	input wire logic trace_clock,
	input wire logic trace_reset,
	input wire logic single_wire_trace_out_a,
	input wire logic single_wire_trace_out_b,
	input wire logic trace_port_clock,
	input wire logic trace_lane_zero
);
	// ----------------------------------------
	// pin rules, trace domain
	// ----------------------------------------
	property p_mirror;
		@(posedge trace_clock) disable iff (trace_reset) single_wire_trace_out_a == single_wire_trace_out_b;
	endproperty
	a_mirror: assert property (p_mirror) else $error("single wire copies differ");
	// the shared pin may carry only one of the two functions
	property p_exclusive;
		@(posedge trace_clock) disable iff (trace_reset)
		(trace_lane_zero || trace_port_clock) |-> !single_wire_trace_out_a;
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("single wire active with lanes");
	property p_clock_toggle;
		@(posedge trace_clock) disable iff (trace_reset) trace_port_clock |=> !trace_port_clock;
	endproperty
	a_clock_toggle: assert property (p_clock_toggle) else $error("trace clock held high");
	// ----------------------------------------
	// stimulus and halt, core domain
	// ----------------------------------------
	property p_busy_set;
		@(posedge clock) disable iff (reset) (stim_write && trace_enable && !stim_busy) |=> stim_busy;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("stimulus write not taken");
	property p_busy_ignore;
		@(posedge clock) disable iff (reset) (!trace_enable && !stim_busy) |=> !stim_busy;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("write taken while disabled");
	// a full fifo may stall the slot, but only for a bounded time
	property p_busy_clear;
		@(posedge clock) disable iff (reset) $rose(stim_busy) |-> ##[1:400] !stim_busy;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("stimulus slot never freed");
	property p_halt_sticky;
		@(posedge clock) disable iff (reset) halt_request |=> halt_request;
	endproperty
	a_halt_sticky: assert property (p_halt_sticky) else $error("halt request dropped");
	property p_halt_cause;
		@(posedge clock) disable iff (reset) $rose(halt_request) |-> $past(comp_function) == DTP_FN_HALT;
	endproperty
	a_halt_cause: assert property (p_halt_cause) else $error("halt without halt function");
	c_halt: cover property (@(posedge clock) disable iff (reset) $rose(halt_request));
	c_busy: cover property (@(posedge clock) disable iff (reset) $rose(stim_busy));
	c_par: cover property (@(posedge trace_clock) disable iff (trace_reset) $rose(trace_port_clock));
endmodule

bind dtp_trace_path dtp_trace_checker u_checker (.clock, .reset, .stim_write, .trace_enable, .comp_function,
	.stim_busy, .halt_request, .trace_clock, .trace_reset, .single_wire_trace_out_a,
	.single_wire_trace_out_b, .trace_port_clock, .trace_lane_zero);

// File: tb/dtp_trace_probe.sv
// passive capture probe on the single wire trace pin
`timescale 1ns/100ps
module dtp_trace_probe (
	// pins from the device
	input wire logic trace_clock,
	input wire logic single_wire_trace_out_a
);
	// deep enough to still hold a packet after a full settle of idle line
	logic [1023:0] hist;
	initial hist = '1;
	// one bit per trace clock, oldest bit at the low end
	always @(posedge trace_clock) begin
		hist <= {single_wire_trace_out_a, hist[1023:1]};
	end
	// idle line is high, so clearing to ones hides old traffic
	task automatic clear();
		hist = '1;
	endtask
	// search the history for a byte sequence sent lsb first
	function automatic logic seen(logic [31:0] pat, int nbytes);
		int w;
		w = nbytes * 8;
		seen = 1'b0;
		for (int i = 0; i + w <= 1024; i++) begin
			if (((hist >> i) & ((1024'h1 << w) - 1024'h1)) == 1024'(pat)) seen = 1'b1;
		end
	endfunction
endmodule

// File: tb/dtp_trace_path_tb.sv
// self-checking bench for the debug trace output path
`timescale 1ns/100ps
module dtp_trace_path_tb import dtp_pkg::*; ;
	logic clock, reset, trace_clock, trace_reset, stim_write, trace_enable, timestamp_enable;
	logic exc_trace_enable, exc_event, data_access, pc_sample_enable, formatter_enable;
	logic [7:0] stim_data, exc_number, d, n;
	logic [1:0] exc_kind, comp_function, out_mode;
	logic [31:0] core_pc, data_addr, comp_value, comp_mask, cycle_compare;
	logic stim_busy, halt_request, single_wire_trace_out_a, single_wire_trace_out_b, trace_port_clock;
	logic trace_lane_zero, trace_lane_one, trace_lane_two, trace_lane_three, a;
	int bad_count, tests_run, cycles;

	dtp_trace_path #(.PC_W(32), .FIFO_LOG2(3)) dut (.clock, .reset, .stim_write, .stim_data, .trace_enable,
		.timestamp_enable, .exc_trace_enable, .exc_event, .exc_kind, .exc_number, .core_pc, .data_addr,
		.data_access, .comp_value, .comp_mask, .comp_function, .cycle_compare, .pc_sample_enable, .out_mode,
		.formatter_enable, .stim_busy, .halt_request, .trace_clock, .trace_reset, .single_wire_trace_out_a,
		.single_wire_trace_out_b, .trace_port_clock, .trace_lane_zero, .trace_lane_one, .trace_lane_two,
		.trace_lane_three);
	dtp_trace_probe u_probe (.trace_clock, .single_wire_trace_out_a);

	// ----------------------------------------
	// clocks, timeout and shared tasks
	// ----------------------------------------
	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	initial begin
		trace_clock = 0;
		#1.7;
		forever #3 trace_clock = ~trace_clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic do_reset();
		reset <= 1;
		trace_reset <= 1;
		repeat (5) @(posedge clock);
		reset <= 0;
		trace_reset <= 0;
		repeat (3) @(posedge clock);
	endtask
	task automatic write_stim(logic [7:0] v);
		stim_write <= 1;
		stim_data <= v;
		@(posedge clock);
		stim_write <= 0;
	endtask
	// long enough for the fifo crossing and a full serial frame
	task automatic settle();
		repeat (80) @(posedge clock);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{reset, trace_reset, stim_write, exc_event, data_access, timestamp_enable} = '0;
		{pc_sample_enable, formatter_enable, stim_data, exc_number, exc_kind, comp_mask} = '0;
		void'($urandom(78134));
		core_pc = $urandom;
		cycle_compare = $urandom;
		comp_value = $urandom;
		data_addr = comp_value;
		trace_enable = 1;
		exc_trace_enable = 1;
		comp_function = DTP_FN_OFF;
		out_mode = DTP_MODE_SINGLE;
		do_reset();
		// corner bytes first, then random ones
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			u_probe.clear();
			write_stim(d);
			#1 check("stim busy", stim_busy, 1);
			settle();
			check("sw packet", u_probe.seen({16'h0, d, DTP_HDR_SW}, 2), 1);
		end
		$display("test software packets done");
		// simultaneous sources: stimulus must leave first
		for (int k = 1; k < 4; k++) begin
			d = 8'($urandom);
			n = 8'($urandom);
			u_probe.clear();
			exc_kind <= 2'(k);
			exc_number <= n;
			exc_event <= 1;
			write_stim(d);
			exc_event <= 0;
			settle();
			check("priority", u_probe.seen({n, DTP_HDR_EXC, d, DTP_HDR_SW}, 4), 1);
		end
		$display("test arbitration done");
		timestamp_enable <= 1;
		u_probe.clear();
		write_stim(d);
		settle();
		check("timestamp", u_probe.seen({8'h0, DTP_HDR_TS, d, DTP_HDR_SW}, 3), 1);
		timestamp_enable <= 0;
		formatter_enable <= 1;
		settle();
		u_probe.clear();
		write_stim(d);
		settle();
		check("formatted", u_probe.seen({d, DTP_SRC_ID, DTP_HDR_SW, DTP_SRC_ID}, 4), 1);
		// left off elsewhere since it only adds overhead
		formatter_enable <= 0;
		trace_enable <= 0;
		write_stim(d);
		#1 check("ignored write", stim_busy, 0);
		trace_enable <= 1;
		$display("test timestamp and formatter done");
		// writes as fast as the slot frees, nothing may be lost
		u_probe.clear();
		for (int i = 0; i < 3; i++) begin
			// let the busy flag settle after the edge before looking at it
			#1;
			for (int t = 0; t < 50 && stim_busy; t++) @(posedge clock);
			write_stim(d + 8'(i));
		end
		settle();
		for (int i = 0; i < 3; i++) check("no loss", u_probe.seen({16'h0, d + 8'(i), DTP_HDR_SW}, 2), 1);
		out_mode <= DTP_MODE_PARALLEL;
		settle();
		write_stim(d);
		@(posedge trace_clock) #1 a = trace_port_clock;
		@(posedge trace_clock) #1 check("trace clock", trace_port_clock, !a);
		check("shared pin", single_wire_trace_out_a, 0);
		out_mode <= DTP_MODE_SINGLE;
		settle();
		$display("test back-pressure and parallel done");
		data_access <= 1;
		@(posedge clock) data_access <= 0;
		repeat (4) @(posedge clock);
		check("no halt", halt_request, 0);
		comp_function <= DTP_FN_HALT;
		repeat (3) @(posedge clock);
		data_access <= 1;
		@(posedge clock) data_access <= 0;
		repeat (4) @(posedge clock);
		check("halt", halt_request, 1);
		do_reset();
		check("halt after reset", halt_request, 0);
		comp_function <= DTP_FN_OFF;
		$display("test halt done");
		finish_test();
	end
endmodule
